/* File: rtl/iosc_clk_ctrl.sv */
// Purpose: internal oscillator control, trim, suspend and clock source selection
// Assumes: sfr port on ref_clk_i; wake and activity pins are asynchronous
// Notes: clocks are carried as one-cycle enable ticks on ref_clk_i
// Notes: source selects are plain inputs; only the system side halves the multiplier

// Overview of operation
// - reset selects internal oscillator for system clock; here sys_sel_i is a plain input that reset does not touch
// - system mux: internal, external, multiplier halved
// - usb mux: internal, external, undivided multiplier
// - internal path to system clock divided 1/2/4/8, reset 8
// - divider code 10 is /2, 11 is /1
// - trim loads factory 12 MHz value on reset
// - each trim step lengthens period 0.0025
// - any reset restores factory oscillator frequency
// - suspend stops oscillator until usb or supply wake
// - usb activity in suspend raises resume interrupt
// - control bit 7 enables oscillator, resets one
// - bit 6 reads one only when frequency ready
module iosc_clk_ctrl #(
    parameter logic [4:0] TRIM_FACTORY = iosc_pkg::IOSC_TRIM_RST_DEFAULT
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire iosc_pkg::iosc_sfr_t sfr_i,
    input wire iosc_pkg::iosc_sys_sel_t sys_sel_i,
    input wire iosc_pkg::iosc_usb_sel_t usb_sel_i,
    input wire logic ext_osc_tick_i,
    input wire logic mul_tick_i,
    input wire logic usb_activity_i,
    input wire logic bus_supply_i,
    input wire logic bus_supply_wake_polarity_i,
    output logic [7:0] sfr_rdata_o,
    output logic system_clock_o,
    output logic usb_clock_o,
    output logic osc_running_o,
    output logic resume_irq_o,
    output logic trim_modified_o
);
    import iosc_pkg::*;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic act_s1_r, act_s2_r, sup_s1_r, sup_s2_r, pol_s1_r, pol_s2_r;

    // reset leaves the supply pair equal, so wake reads true for the first cycles;
    // harmless because suspend stays clear until software writes it
    // two-flop capture of asynchronous pins
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            act_s1_r <= 1'b0;
            act_s2_r <= 1'b0;
            sup_s1_r <= 1'b0;
            sup_s2_r <= 1'b0;
            pol_s1_r <= 1'b0;
            pol_s2_r <= 1'b0;
        end else begin
            act_s1_r <= usb_activity_i;
            act_s2_r <= act_s1_r;
            sup_s1_r <= bus_supply_i;
            sup_s2_r <= sup_s1_r;
            pol_s1_r <= bus_supply_wake_polarity_i;
            pol_s2_r <= pol_s1_r;
        end
    end

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    logic ctrl_wr, trim_wr, ctrl_rd, trim_rd;

    // address match of one register strobe
    function automatic logic sfr_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] reg_addr);
        sfr_hit = strobe && (addr == reg_addr);
    endfunction

    // access decodes shared by the write and read paths
    assign ctrl_wr = sfr_hit(sfr_i.wr, sfr_i.addr, IOSC_CTRL_ADDR);
    assign trim_wr = sfr_hit(sfr_i.wr, sfr_i.addr, IOSC_TRIM_ADDR);
    assign ctrl_rd = sfr_hit(sfr_i.rd, sfr_i.addr, IOSC_CTRL_ADDR);
    assign trim_rd = sfr_hit(sfr_i.rd, sfr_i.addr, IOSC_TRIM_ADDR);

    // ------------------------------------------------------------
    // control and trim registers
    // ------------------------------------------------------------
    logic osc_en_r, osc_en_nxt;
    logic susp_r, susp_nxt;
    iosc_div_t div_r, div_nxt;
    logic [IOSC_TRIM_W-1:0] trim_r, trim_nxt;
    logic trim_mod_r, trim_mod_nxt;
    logic irq_r, irq_nxt;
    logic wake;

    // wake on usb activity or matching supply level
    assign wake = act_s2_r | (sup_s2_r == pol_s2_r);

    // register writes and suspend handling
    always_comb begin
        osc_en_nxt = osc_en_r;
        susp_nxt = susp_r;
        div_nxt = div_r;
        trim_nxt = trim_r;
        trim_mod_nxt = trim_mod_r;
        irq_nxt = 1'b0;
        if (ctrl_wr) begin
            osc_en_nxt = sfr_i.wdata[IOSC_EN_BIT];
            div_nxt = iosc_div_t'(sfr_i.wdata[IOSC_DIV_MSB:IOSC_DIV_LSB]);
            // writing zero to suspend is ignored; only a wake clears it
            if (sfr_i.wdata[IOSC_SUSP_BIT]) begin
                susp_nxt = 1'b1;
            end
        end
        if (trim_wr) begin
            trim_nxt = sfr_i.wdata[IOSC_TRIM_W-1:0];
            // sticky until reset: the usb clock must then avoid the internal source
            if (sfr_i.wdata[IOSC_TRIM_W-1:0] != TRIM_FACTORY) begin
                trim_mod_nxt = 1'b1;
            end
        end
        // resume: clear suspend, pulse interrupt on usb activity
        if (susp_r && wake) begin
            susp_nxt = 1'b0;
            irq_nxt = act_s2_r;
        end
    end

    // control registers
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            osc_en_r <= IOSC_CTRL_RST[IOSC_EN_BIT];
            susp_r <= 1'b0;
            div_r <= IOSC_DIV8;
            trim_r <= TRIM_FACTORY;
            trim_mod_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            osc_en_r <= osc_en_nxt;
            susp_r <= susp_nxt;
            div_r <= div_nxt;
            trim_r <= trim_nxt;
            trim_mod_r <= trim_mod_nxt;
            irq_r <= irq_nxt;
        end
    end

    // ------------------------------------------------------------
    // oscillator model and ready flag
    // ------------------------------------------------------------
    logic [IOSC_ACC_W-1:0] acc_r, acc_nxt, step;
    logic [IOSC_ACC_W:0] acc_sum;
    logic int_tick_r, int_tick_nxt;
    logic [IOSC_SETTLE_W-1:0] settle_r, settle_nxt;
    logic rdy_r, rdy_nxt;
    logic running;
    logic [IOSC_TRIM_W-1:0] trim_seen_r;

    assign running = osc_en_r & ~susp_r;
    // trim offset from the factory value, as distance and direction
    logic trim_up;
    logic [IOSC_TRIM_W-1:0] trim_dist;
    assign trim_up = (trim_r >= TRIM_FACTORY);
    assign trim_dist = trim_up ? (trim_r - TRIM_FACTORY) : (TRIM_FACTORY - trim_r);
    // base step at the factory trim; larger trim means smaller step, so longer period
    assign step = trim_up ? IOSC_BASE_STEP - IOSC_ACC_W'(trim_dist * IOSC_TRIM_STEP)
        : IOSC_BASE_STEP + IOSC_ACC_W'(trim_dist * IOSC_TRIM_STEP);
    assign acc_sum = {1'b0, acc_r} + {1'b0, step};

    // phase accumulation and settle counting
    always_comb begin
        acc_nxt = acc_r;
        int_tick_nxt = 1'b0;
        settle_nxt = settle_r;
        rdy_nxt = 1'b0;
        if (running) begin
            acc_nxt = acc_sum[IOSC_ACC_W-1:0];
            int_tick_nxt = acc_sum[IOSC_ACC_W];
            // any trim change restarts the settle count
            if (trim_r != trim_seen_r) begin
                settle_nxt = '0;
            end else if (settle_r != IOSC_SETTLE_W'(IOSC_SETTLE_CYC)) begin
                settle_nxt = settle_r + 1'b1;
            end
            rdy_nxt = (settle_r == IOSC_SETTLE_W'(IOSC_SETTLE_CYC)) && (trim_r == trim_seen_r);
        end else begin
            settle_nxt = '0;
        end
    end

    // oscillator registers
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            acc_r <= '0;
            int_tick_r <= 1'b0;
            settle_r <= '0;
            rdy_r <= 1'b0;
            // starts on the factory value so ready settles straight after reset
            trim_seen_r <= TRIM_FACTORY;
        end else begin
            acc_r <= acc_nxt;
            int_tick_r <= int_tick_nxt;
            settle_r <= settle_nxt;
            rdy_r <= rdy_nxt;
            trim_seen_r <= trim_r;
        end
    end

    // ------------------------------------------------------------
    // clock selection
    // ------------------------------------------------------------
    logic int_div_tick;
    logic mul_half_r, mul_half_nxt;
    logic sys_r, sys_nxt, usb_r, usb_nxt;
    iosc_ticks_t ticks;

    // post-divider restarts on a ratio change, so no short first period
    iosc_divider u_div (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .tick_i(int_tick_r),
        .div_i(div_r),
        .tick_o(int_div_tick)
    );

    assign ticks = '{int_tick: int_tick_r, ext_tick: ext_osc_tick_i, mul_tick: mul_tick_i};

    // source muxes; sys_sel_i is expected at IOSC_SYS_INT out of reset
    always_comb begin
        mul_half_nxt = mul_half_r ^ ticks.mul_tick;
        // unknown select codes fall back to the internal path
        unique case (sys_sel_i)
            IOSC_SYS_INT: sys_nxt = int_div_tick;
            IOSC_SYS_EXT: sys_nxt = ticks.ext_tick;
            IOSC_SYS_MUL: sys_nxt = ticks.mul_tick & mul_half_r;
            default: sys_nxt = int_div_tick;
        endcase
        unique case (usb_sel_i)
            IOSC_USB_INT: usb_nxt = ticks.int_tick;
            IOSC_USB_EXT: usb_nxt = ticks.ext_tick;
            IOSC_USB_MUL: usb_nxt = ticks.mul_tick;
            default: usb_nxt = ticks.int_tick;
        endcase
    end

    // mux output registers
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mul_half_r <= 1'b0;
            sys_r <= 1'b0;
            usb_r <= 1'b0;
        end else begin
            mul_half_r <= mul_half_nxt;
            sys_r <= sys_nxt;
            usb_r <= usb_nxt;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    logic [7:0] rdata_r, rdata_nxt;
    logic rdy_visible;

    // flag only while running on the current trim, hiding the lag of rdy_r
    assign rdy_visible = rdy_r & running & (trim_r == trim_seen_r);

    // read mux; unused bits and unmapped addresses give zero
    always_comb begin
        rdata_nxt = 8'h00;
        if (ctrl_rd) begin
            rdata_nxt[IOSC_EN_BIT] = osc_en_r;
            rdata_nxt[IOSC_RDY_BIT] = rdy_visible;
            rdata_nxt[IOSC_SUSP_BIT] = susp_r;
            rdata_nxt[IOSC_DIV_MSB:IOSC_DIV_LSB] = div_r;
        end else if (trim_rd) begin
            // trim shows its five bits; upper bits read zero
            rdata_nxt[IOSC_TRIM_W-1:0] = trim_r;
        end
    end

    // read data register
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // every output comes straight from a register
    assign sfr_rdata_o = rdata_r;
    assign system_clock_o = sys_r;
    assign usb_clock_o = usb_r;
    assign osc_running_o = int_tick_r;
    assign resume_irq_o = irq_r;
    assign trim_modified_o = trim_mod_r;
endmodule

/* File: pkg/iosc_pkg.sv */
// Purpose: shared constants and types for the internal oscillator and clock selection block
// Assumes: 8-bit special function register port, single 100 MHz reference clock
// Notes: the oscillator itself is modelled as a phase accumulator stepped on ref_clk_i
package iosc_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] IOSC_CTRL_ADDR = 8'hB2;
    localparam logic [7:0] IOSC_TRIM_ADDR = 8'hB3;
    localparam logic [7:0] IOSC_CTRL_RST = 8'h80;
    localparam logic [4:0] IOSC_TRIM_RST_DEFAULT = 5'h10; // arbitrary stand-in for the factory value
    localparam int IOSC_EN_BIT = 7;
    localparam int IOSC_RDY_BIT = 6;
    localparam int IOSC_SUSP_BIT = 5;
    localparam int IOSC_DIV_LSB = 0;
    localparam int IOSC_DIV_MSB = 1;
    localparam int IOSC_TRIM_W = 5;

    // ------------------------------------------------------------
    // oscillator model timing
    // ------------------------------------------------------------
    localparam int IOSC_REF_MHZ = 100;
    localparam int IOSC_BASE_MHZ = 12;
    localparam int IOSC_ACC_W = 24;
    // base step: 12/100 of full scale per reference cycle
    localparam logic [IOSC_ACC_W-1:0] IOSC_BASE_STEP =
        IOSC_ACC_W'((64'(IOSC_BASE_MHZ) << IOSC_ACC_W) / 64'(IOSC_REF_MHZ));
    // one trim step lengthens the period by 0.0025, i.e. shrinks the step by 1/400
    localparam int IOSC_TRIM_DENOM = 400;
    localparam logic [IOSC_ACC_W-1:0] IOSC_TRIM_STEP = IOSC_ACC_W'(IOSC_BASE_STEP / IOSC_TRIM_DENOM);
    localparam int IOSC_SETTLE_NS = 1000;
    localparam int IOSC_SETTLE_CYC = (IOSC_SETTLE_NS * IOSC_REF_MHZ + 999) / 1000;
    localparam int IOSC_SETTLE_W = 8;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        IOSC_DIV8 = 2'b00,
        IOSC_DIV4 = 2'b01,
        IOSC_DIV2 = 2'b10,
        IOSC_DIV1 = 2'b11
    } iosc_div_t;

    typedef enum logic [1:0] {
        IOSC_SYS_INT = 2'b00,
        IOSC_SYS_EXT = 2'b01,
        IOSC_SYS_MUL = 2'b10
    } iosc_sys_sel_t;

    typedef enum logic [1:0] {
        IOSC_USB_INT = 2'b00,
        IOSC_USB_EXT = 2'b01,
        IOSC_USB_MUL = 2'b10
    } iosc_usb_sel_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } iosc_sfr_t;

    typedef struct packed {
        logic int_tick;
        logic ext_tick;
        logic mul_tick;
    } iosc_ticks_t;
endpackage

/* File: rtl/iosc_divider.sv */
// Purpose: post-divider of the internal oscillator tick by 1, 2, 4 or 8
// Assumes: tick_i is a one-cycle pulse on ref_clk_i
// Notes: counter restarts when the ratio changes so no runt period
module iosc_divider (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic tick_i,
    input wire iosc_pkg::iosc_div_t div_i,
    output logic tick_o
);
    import iosc_pkg::*;

    logic [2:0] cnt_r, cnt_nxt;
    logic tick_r, tick_nxt;
    iosc_div_t div_r, div_nxt;

    // terminal count per ratio
    function automatic logic [2:0] term_of(input iosc_div_t d);
        unique case (d)
            IOSC_DIV8: term_of = 3'h7;
            IOSC_DIV4: term_of = 3'h3;
            IOSC_DIV2: term_of = 3'h1;
            IOSC_DIV1: term_of = 3'h0;
        endcase
    endfunction

    // next count and output pulse
    always_comb begin
        cnt_nxt = cnt_r;
        tick_nxt = 1'b0;
        div_nxt = div_i;
        if (div_i != div_r) begin
            cnt_nxt = 3'h0;
        end else if (tick_i) begin
            if (cnt_r >= term_of(div_r)) begin
                cnt_nxt = 3'h0;
                tick_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 3'h1;
            end
        end
    end

    // state registers
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_r <= 3'h0;
            tick_r <= 1'b0;
            div_r <= IOSC_DIV8;
        end else begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
            div_r <= div_nxt;
        end
    end

    assign tick_o = tick_r;
endmodule

/* File: bench/iosc_clk_ctrl_props.sv */
// Purpose: port-level checks of the oscillator control block
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound into every instance of the top module
module iosc_clk_ctrl_props
    import iosc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire iosc_pkg::iosc_sfr_t sfr_i,
    input wire iosc_pkg::iosc_sys_sel_t sys_sel_i,
    input wire iosc_pkg::iosc_usb_sel_t usb_sel_i,
    input wire logic ext_osc_tick_i,
    input wire logic mul_tick_i,
    input wire logic usb_activity_i,
    input wire logic bus_supply_i,
    input wire logic bus_supply_wake_polarity_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic system_clock_o,
    input wire logic usb_clock_o,
    input wire logic osc_running_o,
    input wire logic resume_irq_o,
    input wire logic trim_modified_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    logic [2:0] act_age_r;
    // --------------------------------
    // cycles since last usb activity
    // --------------------------------
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) act_age_r <= 3'h7;
        else if (usb_activity_i) act_age_r <= 3'h0;
        else if (act_age_r != 3'h7) act_age_r <= act_age_r + 3'h1;
    end
    // --------------------------------
    // sequences and assertions
    // --------------------------------
    sequence s_rd(logic [7:0] a);
        sfr_i.rd && sfr_i.addr == a;
    endsequence
    sequence s_sys(iosc_sys_sel_t s);
        sys_sel_i == s ##1 sys_sel_i == s;
    endsequence
    AST_RD_IDLE: assert property (!sfr_i.rd |=> sfr_rdata_o == 8'h00) else $error("read data not idle");
    AST_UNUSED: assert property (s_rd(IOSC_CTRL_ADDR) |=> sfr_rdata_o[4:2] == 3'h0) else $error("unused set");
    AST_RDY: assert property (s_rd(IOSC_CTRL_ADDR) |=>
        !(sfr_rdata_o[6] && (!sfr_rdata_o[7] || sfr_rdata_o[5]))) else $error("ready while stopped");
    AST_IRQ_PULSE: assert property (resume_irq_o |=> !resume_irq_o) else $error("irq longer than one");
    AST_IRQ_CAUSE: assert property (resume_irq_o |-> act_age_r < 3'h6) else $error("irq without activity");
    AST_SYS_EXT: assert property (s_sys(IOSC_SYS_EXT) |-> system_clock_o == $past(ext_osc_tick_i))
        else $error("sys ext mismatch");
    AST_SYS_MUL: assert property (s_sys(IOSC_SYS_MUL) ##0 system_clock_o |-> $past(mul_tick_i))
        else $error("sys mul mismatch");
    AST_USB_EXT: assert property (usb_sel_i == IOSC_USB_EXT && $past(usb_sel_i) == IOSC_USB_EXT
        |-> usb_clock_o == $past(ext_osc_tick_i)) else $error("usb ext mismatch");
    AST_USB_MUL: assert property (usb_sel_i == IOSC_USB_MUL && $past(usb_sel_i) == IOSC_USB_MUL
        |-> usb_clock_o == $past(mul_tick_i)) else $error("usb mul mismatch");
    AST_TRIM_HOLD: assert property (trim_modified_o |=> trim_modified_o) else $error("trim flag dropped");
endmodule

bind iosc_clk_ctrl iosc_clk_ctrl_props u_iosc_clk_ctrl_props (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .sfr_i(sfr_i), .sys_sel_i(sys_sel_i), .usb_sel_i(usb_sel_i), .ext_osc_tick_i(ext_osc_tick_i),
    .mul_tick_i(mul_tick_i), .usb_activity_i(usb_activity_i), .bus_supply_i(bus_supply_i),
    .bus_supply_wake_polarity_i(bus_supply_wake_polarity_i), .sfr_rdata_o(sfr_rdata_o),
    .system_clock_o(system_clock_o), .usb_clock_o(usb_clock_o), .osc_running_o(osc_running_o),
    .resume_irq_o(resume_irq_o), .trim_modified_o(trim_modified_o));

/* File: bench/iosc_clk_ctrl_bench.sv */
// Purpose: self-checking bench of the oscillator control block
// Assumes: 100 MHz clock, tick sources made here
// Notes: tick rates compared with one tick of slack
module iosc_clk_ctrl_bench import iosc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; $display("[ERR] %s exp=%0h got=%0h", nm, e, g); end end
    typedef struct {logic [7:0] w; logic [7:0] e; int dv;} iosc_row_t;
    iosc_row_t rows[4] = '{'{8'h9C, 8'h80, 8}, '{8'h9D, 8'h81, 4}, '{8'h9E, 8'h82, 2}, '{8'h9F, 8'h83, 1}};
    logic ref_clk_i = 0, resetn_i = 0, ext_tick = 0, mul_tick = 0, usb_act = 0, supply = 0, wake_pol = 1;
    iosc_sfr_t sfr_i = '0;
    iosc_sys_sel_t sys_sel_i = IOSC_SYS_INT;
    iosc_usb_sel_t usb_sel_i = IOSC_USB_INT;
    logic [7:0] rdata;
    logic sys_clk, usb_clk, osc_run, irq, trim_mod;
    int fails = 0, comparisons = 0, cyc = 0, cnt[6] = '{0, 0, 0, 0, 0, 0}, d[6];
    iosc_clk_ctrl u_iosc_clk_ctrl (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .sfr_i(sfr_i),
        .sys_sel_i(sys_sel_i), .usb_sel_i(usb_sel_i), .ext_osc_tick_i(ext_tick), .mul_tick_i(mul_tick),
        .usb_activity_i(usb_act), .bus_supply_i(supply), .bus_supply_wake_polarity_i(wake_pol),
        .sfr_rdata_o(rdata), .system_clock_o(sys_clk), .usb_clock_o(usb_clk), .osc_running_o(osc_run),
        .resume_irq_o(irq), .trim_modified_o(trim_mod));
    // clock
    initial begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    // tick sources, output counters, timeout
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        ext_tick <= (cyc % 7 == 0);
        mul_tick <= (cyc % 3 == 0);
        cnt <= '{cnt[0] + osc_run, cnt[1] + sys_clk, cnt[2] + usb_clk, cnt[3] + ext_tick, cnt[4] + mul_tick,
            cnt[5] + irq};
        if (cyc == 40000) begin
            fails++;
            end_of_test();
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic end_of_test();
        if (fails == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic rst();
        @(posedge ref_clk_i) resetn_i <= 1'b0;
        repeat (5) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk_i) sfr_i <= {1'b1, 1'b0, a, v};
        @(posedge ref_clk_i) sfr_i <= '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk_i) sfr_i <= {1'b0, 1'b1, a, 8'h00};
        @(posedge ref_clk_i) sfr_i <= '0;
        @(negedge ref_clk_i) v = rdata;
    endtask
    task automatic win(input int n);
        int s[6];
        s = cnt;
        repeat (n) @(posedge ref_clk_i);
        foreach (d[i]) d[i] = cnt[i] - s[i];
    endtask
    function automatic bit near(int a, int b);
        return (a - b) inside {[-1:1]};
    endfunction
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] v;
        int base;
        rst();
        rd(IOSC_CTRL_ADDR, v);
        `CHK("ctrl_rst", 8'h80, v)
        rd(IOSC_TRIM_ADDR, v);
        `CHK("trim_rst", {3'h0, IOSC_TRIM_RST_DEFAULT}, v)
        win(800);
        `CHK("div_rst", 1'b1, near(d[0] / 8, d[1]))
        `CHK("base_rate", 1'b1, near(800 * IOSC_BASE_MHZ / IOSC_REF_MHZ, d[0]))
        rd(IOSC_CTRL_ADDR, v);
        `CHK("ready", 8'hC0, v)
        foreach (rows[i]) begin
            wr(IOSC_CTRL_ADDR, rows[i].w);
            rd(IOSC_CTRL_ADDR, v);
            `CHK("ctrl_wr", rows[i].e, v & 8'hBF)
            win(800);
            `CHK("div", 1'b1, near(d[0] / rows[i].dv, d[1]))
        end
        for (int i = 0; i < 3; i++) begin
            sys_sel_i <= iosc_sys_sel_t'(i);
            usb_sel_i <= iosc_usb_sel_t'(i);
            win(3);
            win(300);
            `CHK("sys_src", 1'b1, near(i == 0 ? d[0] : i == 1 ? d[3] : d[4] / 2, d[1]))
            `CHK("usb_src", 1'b1, near(i == 0 ? d[0] : i == 1 ? d[3] : d[4], d[2]))
        end
        sys_sel_i <= IOSC_SYS_INT;
        usb_sel_i <= IOSC_USB_INT;
        win(2000);
        base = d[0];
        usb_sel_i <= IOSC_USB_EXT;
        wr(IOSC_TRIM_ADDR, 8'h18);
        rd(IOSC_CTRL_ADDR, v);
        `CHK("rdy_trim", 1'b0, v[6])
        `CHK("trim_mod", 1'b1, trim_mod)
        win(2000);
        `CHK("slower", 1'b1, base - d[0] >= 3)
        rst();
        rd(IOSC_TRIM_ADDR, v);
        `CHK("trim_back", {3'h0, IOSC_TRIM_RST_DEFAULT}, v)
        `CHK("trim_clr", 1'b0, trim_mod)
        wr(IOSC_CTRL_ADDR, 8'h00);
        win(3);
        win(200);
        `CHK("osc_off", 0, d[0])
        rd(IOSC_CTRL_ADDR, v);
        `CHK("ctrl_off", 8'h00, v)
        wr(IOSC_CTRL_ADDR, 8'h80);
        win(200);
        for (int k = 0; k < 2; k++) begin
            wr(IOSC_CTRL_ADDR, 8'hA0);
            win(3);
            win(200);
            `CHK("susp_stop", 0, d[0])
            rd(IOSC_CTRL_ADDR, v);
            `CHK("susp_bit", 8'hA0, v)
            @(posedge ref_clk_i);
            if (k == 0) usb_act <= 1'b1;
            else supply <= wake_pol;
            win(10);
            `CHK("irq", 1 - k, d[5])
            usb_act <= 1'b0; // irq checked; transceiver re-enable sits outside this block
            supply <= ~wake_pol;
            rd(IOSC_CTRL_ADDR, v);
            `CHK("susp_clr", 1'b0, v[5])
            win(100);
            `CHK("resumed", 1'b1, d[0] > 0)
        end
        end_of_test();
    end
endmodule
